// [hdl/athn_pkg.sv]
package athn_pkg;

  // bus geometry
  localparam int ATHN_ADR_W   = 8;
  localparam int ATHN_DAT_W   = 32;
  localparam int ATHN_IDX_W   = 6;

  // register word indices (byte address = index * 4)
  localparam logic [5:0] ATHN_IDX_CTRL     = 6'h00;
  localparam logic [5:0] ATHN_IDX_STATUS   = 6'h01;
  localparam logic [5:0] ATHN_IDX_INT_STAT = 6'h02;
  localparam logic [5:0] ATHN_IDX_INT_MASK = 6'h03;
  localparam logic [5:0] ATHN_IDX_SRC      = 6'h08;
  localparam logic [5:0] ATHN_IDX_DST      = 6'h10;

  // operand storage
  localparam int ATHN_SRC_WORDS = 8;
  localparam int ATHN_DST_WORDS = 4;
  localparam int ATHN_CHARS     = 16;

  // control register fields
  localparam int ATHN_CTRL_COND  = 0;
  localparam int ATHN_CTRL_ONCE  = 1;
  localparam int ATHN_CTRL_WIDTH = 2;

  // status register fields
  localparam int ATHN_ST_FAULT = 0;
  localparam int ATHN_ST_ZERO  = 1;
  localparam int ATHN_ST_SIGN  = 2;

  // interrupt status / mask fields
  localparam int ATHN_INT_W     = 2;
  localparam int ATHN_INT_DONE  = 0;
  localparam int ATHN_INT_FAULT = 1;

  // reset values
  localparam logic [15:0]         ATHN_WORD_RST = 16'h0000;
  localparam logic [ATHN_INT_W-1:0] ATHN_INT_RST  = 2'h0;

  // conversion width select
  typedef enum logic [1:0] {
    ATHN_W16  = 2'b00,
    ATHN_W32  = 2'b01,
    ATHN_W64  = 2'b10,
    ATHN_WRSV = 2'b11
  } athn_width_e;

  // characters taken per width, one bit per character, first character in bit 0
  localparam logic [15:0] ATHN_NEED_W16 = 16'h000F;
  localparam logic [15:0] ATHN_NEED_W32 = 16'h00FF;
  localparam logic [15:0] ATHN_NEED_W64 = 16'hFFFF;

  // destination words written per width
  localparam logic [3:0] ATHN_DMSK_W16 = 4'h1;
  localparam logic [3:0] ATHN_DMSK_W32 = 4'h3;
  localparam logic [3:0] ATHN_DMSK_W64 = 4'hF;

  // ascii code bounds of hex digits
  localparam logic [7:0] ATHN_CH_0     = 8'h30;
  localparam logic [7:0] ATHN_CH_9     = 8'h39;
  localparam logic [7:0] ATHN_CH_UA    = 8'h41;
  localparam logic [7:0] ATHN_CH_UF    = 8'h46;
  localparam logic [7:0] ATHN_CH_LA    = 8'h61;
  localparam logic [7:0] ATHN_CH_LF    = 8'h66;
  localparam logic [3:0] ATHN_LET_OFS  = 4'h9;

endpackage

// [hdl/athn_top.sv]
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Contract
// - 16-bit mode: four characters from two source words form one destination word.
// - fault indicator set if any used character is not hex, cleared otherwise.
// - on an invalid character the destination words stay untouched.
// - valid characters are 0-9, a-f, A-F; both letter cases give ten to fifteen.
// - zero indicator set when the converted result is zero, cleared otherwise.
// - sign indicator follows the most significant bit of the converted result.
// - runs every cycle while condition is on, or once on its rising edge.
// - 32-bit mode: eight characters from four words fill two destination words.
// - 64-bit mode: sixteen characters, same validation and indicators as narrower modes.
// - 64-bit mode reads eight source words and fills four destination words.
module athn_top (
  // clock, reset, enable
  input  wire logic                            i_clk,
  input  wire logic                            i_srst,
  input  wire logic                            i_ce,
  // wishbone slave
  input  wire logic                            i_wb_cyc,
  input  wire logic                            i_wb_stb,
  input  wire logic                            i_wb_we,
  input  wire logic [athn_pkg::ATHN_ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                      i_wb_sel,
  input  wire logic [athn_pkg::ATHN_DAT_W-1:0] i_wb_dat,
  output logic                                 o_wb_ack,
  output logic [athn_pkg::ATHN_DAT_W-1:0]      o_wb_dat,
  // indicators and interrupt
  output logic                                 o_fault,
  output logic                                 o_zero,
  output logic                                 o_sign,
  output logic                                 o_irq
);
  import athn_pkg::*;

  logic [15:0]           src_q [ATHN_SRC_WORDS];
  logic [15:0]           dst_q [ATHN_DST_WORDS];
  logic                  cond_q;
  logic                  cond_prev_q;
  logic                  once_q;
  athn_width_e           width_q;
  logic                  fault_q;
  logic                  zero_q;
  logic                  sign_q;
  logic [ATHN_INT_W-1:0] int_stat_q;
  logic [ATHN_INT_W-1:0] int_mask_q;
  logic                  ack_q;
  logic [31:0]           rdat_q;
  logic [31:0]           rdat_d;

  logic                  wb_req;
  logic                  wb_wr;
  logic [5:0]            word_idx;
  logic [31:0]           wr_mask;
  logic [7:0]            chr   [ATHN_CHARS];
  logic [3:0]            nib   [ATHN_CHARS];
  logic [15:0]           chr_ok;
  logic [63:0]           all_nib;
  logic [63:0]           value;
  logic [15:0]           need;
  logic [3:0]            dst_msk;
  logic                  width_ok;
  logic                  all_valid;
  logic                  res_sign;
  logic                  exec;
  logic                  ev_done;
  logic                  ev_fault;
  logic [ATHN_INT_W-1:0] int_clr;

  // ---------------- bus decode ----------------
  assign wb_req   = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wb_wr    = wb_req & i_wb_we;
  assign word_idx = i_wb_adr[7:2];
  assign wr_mask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // answer one cycle after the request is seen; drops the cycle after
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cond_q  <= 1'b0;
      once_q  <= 1'b0;
      width_q <= ATHN_W16;
    end else if (i_ce && wb_wr && word_idx == ATHN_IDX_CTRL && i_wb_sel[0]) begin
      cond_q  <= i_wb_dat[ATHN_CTRL_COND];
      once_q  <= i_wb_dat[ATHN_CTRL_ONCE];
      width_q <= athn_width_e'(i_wb_dat[ATHN_CTRL_WIDTH +: 2]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      int_mask_q <= ATHN_INT_RST;
    end else if (i_ce && wb_wr && word_idx == ATHN_IDX_INT_MASK && i_wb_sel[0]) begin
      int_mask_q <= i_wb_dat[ATHN_INT_W-1:0];
    end
  end

  genvar gk;
  generate
    for (gk = 0; gk < ATHN_SRC_WORDS; gk++) begin : g_src
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          src_q[gk] <= ATHN_WORD_RST;
        end else if (i_ce && wb_wr && word_idx == ATHN_IDX_SRC + 6'(gk)) begin
          src_q[gk] <= (src_q[gk] & ~wr_mask[15:0]) | (i_wb_dat[15:0] & wr_mask[15:0]);
        end
      end
    end
  endgenerate

  // ---------------- character decode ----------------
  genvar gj;
  generate
    for (gj = 0; gj < ATHN_CHARS; gj++) begin : g_chr
      logic is_dig;
      logic is_let;
      // even character sits in the upper byte of its word
      assign chr[gj]    = src_q[gj/2][8*(1-(gj%2)) +: 8];
      assign is_dig     = (chr[gj] >= ATHN_CH_0) && (chr[gj] <= ATHN_CH_9);
      assign is_let     = ((chr[gj] >= ATHN_CH_UA) && (chr[gj] <= ATHN_CH_UF)) ||
                          ((chr[gj] >= ATHN_CH_LA) && (chr[gj] <= ATHN_CH_LF));
      assign chr_ok[gj] = is_dig | is_let;
      assign nib[gj]    = is_let ? chr[gj][3:0] + ATHN_LET_OFS : chr[gj][3:0];
      // first character lands in the top nibble
      assign all_nib[63-4*gj -: 4] = nib[gj];
    end
  endgenerate

  always_comb begin
    need     = ATHN_NEED_W16;
    dst_msk  = ATHN_DMSK_W16;
    value    = {48'h0000_0000_0000, all_nib[63:48]};
    res_sign = all_nib[63];
    width_ok = 1'b1;
    case (width_q)
      ATHN_W16: begin
        need     = ATHN_NEED_W16;
        dst_msk  = ATHN_DMSK_W16;
        value    = {48'h0000_0000_0000, all_nib[63:48]};
        res_sign = all_nib[63];
      end
      ATHN_W32: begin
        need     = ATHN_NEED_W32;
        dst_msk  = ATHN_DMSK_W32;
        value    = {32'h0000_0000, all_nib[63:32]};
        res_sign = all_nib[63];
      end
      ATHN_W64: begin
        need     = ATHN_NEED_W64;
        dst_msk  = ATHN_DMSK_W64;
        value    = all_nib;
        res_sign = all_nib[63];
      end
      default: begin
        // reserved width never executes
        width_ok = 1'b0;
      end
    endcase
  end

  assign all_valid = &(chr_ok | ~need);

  // ---------------- execution ----------------
  // once mode fires only on the cycle the condition rises
  assign exec     = i_ce & width_ok & cond_q & (~once_q | ~cond_prev_q);
  assign ev_done  = exec & all_valid;
  assign ev_fault = exec & ~all_valid;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cond_prev_q <= 1'b0;
    end else if (i_ce) begin
      cond_prev_q <= cond_q;
    end
  end

  generate
    for (gk = 0; gk < ATHN_DST_WORDS; gk++) begin : g_dst
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          dst_q[gk] <= ATHN_WORD_RST;
        end else if (ev_done && dst_msk[gk]) begin
          dst_q[gk] <= value[16*gk +: 16];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fault_q <= 1'b0;
    end else if (exec) begin
      fault_q <= ~all_valid;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      zero_q <= 1'b0;
      sign_q <= 1'b0;
    end else if (ev_done) begin
      zero_q <= (value == 64'h0000_0000_0000_0000);
      sign_q <= res_sign;
    end
  end

  // ---------------- interrupts ----------------
  assign int_clr = (wb_wr && word_idx == ATHN_IDX_INT_STAT && i_wb_sel[0]) ?
                   i_wb_dat[ATHN_INT_W-1:0] : ATHN_INT_RST;

  // a new event outranks a write-one-to-clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      int_stat_q <= ATHN_INT_RST;
    end else if (i_ce) begin
      int_stat_q <= (int_stat_q & ~int_clr) | {ev_fault, ev_done};
    end
  end

  // ---------------- read path ----------------
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (word_idx == ATHN_IDX_CTRL) begin
      rdat_d[ATHN_CTRL_COND]         = cond_q;
      rdat_d[ATHN_CTRL_ONCE]         = once_q;
      rdat_d[ATHN_CTRL_WIDTH +: 2]   = width_q;
    end else if (word_idx == ATHN_IDX_STATUS) begin
      rdat_d[ATHN_ST_FAULT] = fault_q;
      rdat_d[ATHN_ST_ZERO]  = zero_q;
      rdat_d[ATHN_ST_SIGN]  = sign_q;
    end else if (word_idx == ATHN_IDX_INT_STAT) begin
      rdat_d[ATHN_INT_W-1:0] = int_stat_q;
    end else if (word_idx == ATHN_IDX_INT_MASK) begin
      rdat_d[ATHN_INT_W-1:0] = int_mask_q;
    end else if (word_idx >= ATHN_IDX_SRC && word_idx < ATHN_IDX_SRC + 6'(ATHN_SRC_WORDS)) begin
      rdat_d[15:0] = src_q[3'(word_idx - ATHN_IDX_SRC)];
    end else if (word_idx >= ATHN_IDX_DST && word_idx < ATHN_IDX_DST + 6'(ATHN_DST_WORDS)) begin
      rdat_d[15:0] = dst_q[2'(word_idx - ATHN_IDX_DST)];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdat_q <= 32'h0000_0000;
    end else if (i_ce && wb_req) begin
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_fault  = fault_q;
  assign o_zero   = zero_q;
  assign o_sign   = sign_q;
  assign o_irq    = |(int_stat_q & int_mask_q);

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_bad_exec;
    exec && !all_valid;
  endsequence

  sequence s_rise_held;
    once_q && cond_q && i_ce ##1 (once_q && cond_q && i_ce);
  endsequence

  sequence s_bus_req;
    i_ce && wb_req ##1 (ack_q && i_ce);
  endsequence

  a_fault_on_bad: assert property (s_bad_exec |=> fault_q && int_stat_q[ATHN_INT_FAULT])
    else $error("fault indicator not raised on bad character");

  a_fault_clr_ok: assert property (ev_done |=> !fault_q)
    else $error("fault indicator not cleared on good conversion");

  a_dst_kept_bad: assert property (s_bad_exec |=> $stable({dst_q[3], dst_q[2], dst_q[1], dst_q[0]}))
    else $error("destination changed after invalid character");

  a_word16_msb: assert property (ev_done && width_q == ATHN_W16 |=>
                                 dst_q[0][15:12] == $past(nib[0]) && dst_q[0][3:0] == $past(nib[3])
                                 && $stable(dst_q[1]))
    else $error("16-bit result word wrong");

  a_char_order: assert property (ev_done |=> dst_q[0][7:4] == $past(nib[need == ATHN_NEED_W16 ? 2 :
                                 need == ATHN_NEED_W32 ? 6 : 14]))
    else $error("character order into result wrong");

  a_hex_letter: assert property (chr[0] == ATHN_CH_LA || chr[0] == ATHN_CH_UA |-> chr_ok[0] && nib[0] == 4'hA)
    else $error("letter digit decoded wrongly");

  a_word32_pair: assert property (ev_done && width_q == ATHN_W32 |=>
                                  {dst_q[1], dst_q[0]} == $past(all_nib[63:32]) && $stable(dst_q[2]))
    else $error("32-bit result words wrong");

  a_word64_quad: assert property (ev_done && width_q == ATHN_W64 |=>
                                  {dst_q[3], dst_q[2], dst_q[1], dst_q[0]} == $past(all_nib))
    else $error("64-bit result words wrong");

  a_zero_flag: assert property (ev_done |=> zero_q == ($past(value) == 64'h0000_0000_0000_0000))
    else $error("zero indicator wrong");

  a_sign_flag: assert property (ev_done && width_q == ATHN_W32 |=> sign_q == $past(all_nib[63]))
    else $error("sign indicator wrong");

  a_once_single: assert property (s_rise_held |-> !exec)
    else $error("once mode executed while condition held");

  a_each_cycle: assert property (i_ce && cond_q && !once_q && width_ok |-> exec)
    else $error("each-cycle mode missed a cycle");

  a_bus_answer: assert property (s_bus_req |=> !ack_q)
    else $error("ack held longer than one cycle");

  a_sign_first: assert property (ev_done |=> sign_q == $past(nib[0][3]))
    else $error("sign indicator not the msb of the first digit");

  a_flags_kept: assert property (s_bad_exec |=> $stable(zero_q) && $stable(sign_q))
    else $error("zero or sign changed on invalid character");

  a_digit_value: assert property (chr[0] >= ATHN_CH_0 && chr[0] <= ATHN_CH_9 |->
                                  chr_ok[0] && nib[0] == chr[0][3:0])
    else $error("decimal digit decoded wrongly");

  a_non_hex: assert property (chr[0] == 8'h47 || chr[0] == 8'h3A || chr[0] == 8'h60 |-> !chr_ok[0])
    else $error("non-hex character accepted");

  a_done_event: assert property (ev_done |=> int_stat_q[ATHN_INT_DONE])
    else $error("done event not recorded");

  a_fault_hold: assert property (!exec |=> $stable(fault_q))
    else $error("fault indicator moved without execution");

  a_ce_freeze: assert property (!i_ce |=> $stable(ack_q) && $stable(fault_q) && $stable({dst_q[1], dst_q[0]}))
    else $error("state moved while clock enable low");

endmodule

// [sim/athn_seq.sv]
`timescale 1ns/1ps
// wishbone master standing in for the instruction sequencer
module athn_seq
  import athn_pkg::*;
(
  // clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_srst,
  // request from the bench
  input  wire logic                            i_go,
  input  wire logic                            i_we,
  input  wire logic [athn_pkg::ATHN_ADR_W-1:0] i_adr,
  input  wire logic [athn_pkg::ATHN_DAT_W-1:0] i_dat,
  output logic                                 o_done,
  output logic [athn_pkg::ATHN_DAT_W-1:0]      o_rdat,
  // wishbone master
  output logic                                 o_wb_cyc,
  output logic                                 o_wb_stb,
  output logic                                 o_wb_we,
  output logic [athn_pkg::ATHN_ADR_W-1:0]      o_wb_adr,
  output logic [3:0]                           o_wb_sel,
  output logic [athn_pkg::ATHN_DAT_W-1:0]      o_wb_dat,
  input  wire logic                            i_wb_ack,
  input  wire logic [athn_pkg::ATHN_DAT_W-1:0] i_wb_dat
);
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
    end else if (o_wb_cyc && i_wb_ack) begin
      // released lines show the inverse so stale values cannot pass
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_adr <= ~o_wb_adr;
      o_wb_dat <= ~o_wb_dat;
      o_rdat   <= i_wb_dat;
      o_done   <= 1'b1;
    end else if (i_go && !o_wb_cyc && !o_done) begin
      // a condition rise is one write of cond, the edge itself is the device's
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we  <= i_we;
      o_wb_adr <= i_adr;
      o_wb_sel <= 4'hF;
      o_wb_dat <= i_dat;
    end
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import athn_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1, go = 1'b0, we = 1'b0, done, cyc, stb, wwe, ack, flt, zro, sgn, irq;
  logic ce = 1'b1;
  logic [7:0] adr = 8'h00, wadr;
  logic [31:0] dat = 32'h0, rdat, wdat, ddat, odat;
  logic [3:0] sel;
  int fail_count = 0, cmp_count = 0, cyc_n = 0;
  athn_seq athn_seq_inst (.i_clk(i_clk), .i_srst(i_srst), .i_go(go), .i_we(we), .i_adr(adr), .i_dat(dat),
    .o_done(done), .o_rdat(rdat), .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(wwe), .o_wb_adr(wadr),
    .o_wb_sel(sel), .o_wb_dat(wdat), .i_wb_ack(ack), .i_wb_dat(odat));
  athn_top athn_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(wwe), .i_wb_adr(wadr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(odat),
    .o_fault(flt), .o_zero(zro), .o_sign(sgn), .o_irq(irq));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk);
    go <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge i_clk);
    go <= 1'b0;
    while (done !== 1'b1) @(negedge i_clk);
    r = rdat;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), r, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // sixteen characters, first one into the upper byte of source word 0
  task automatic src(input logic [127:0] s);
    for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), {16'h0, s[127 - 16 * i -: 16]});
  endtask
  task automatic run(input athn_width_e w);
    wr(8'h00, {28'h0, w, 2'b11});
    wr(8'h00, 32'h0);
  endtask
  // expected flags as {sign, zero, fault}
  task automatic flags(input logic [2:0] e);
    chk("flag pins", {29'h0, sgn, zro, flt}, {29'h0, e});
    rd(8'h04, {29'h0, e});
  endtask
  task automatic t_reset();
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h40, 32'h0);
    flags(3'b000);
    wr(8'h80, 32'h5555_5555);
    rd(8'h80, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_w16();
    src("12AB............");
    run(ATHN_W16);
    rd(8'h40, 32'h0000_12AB);
    flags(3'b000);
    src("fedc0000........");
    run(ATHN_W16);
    rd(8'h40, 32'h0000_FEDC);
    flags(3'b100);
    src("0000zzzz........");
    run(ATHN_W16);
    rd(8'h40, 32'h0000_0000);
    flags(3'b010);
    $display("test w16 done");
  endtask
  task automatic t_chars();
    logic [7:0] c [12] = '{8'h30, 8'h39, 8'h41, 8'h46, 8'h61, 8'h66, 8'h2F, 8'h3A, 8'h40, 8'h47, 8'h60, 8'h67};
    logic [3:0] v;
    logic [15:0] prev;
    prev = 16'h0;
    for (int i = 0; i < 12; i++) begin
      wr(8'h20, {16'h0, c[i], 8'h30});
      wr(8'h24, 32'h0000_3030);
      run(ATHN_W16);
      v = (c[i] <= 8'h39) ? c[i][3:0] : c[i][3:0] + 4'h9;
      if (i < 6) prev = {v, 12'h000};
      chk("fault pin", {31'h0, flt}, {31'h0, i >= 6});
      rd(8'h40, {16'h0, prev});
    end
    $display("test chars done");
  endtask
  task automatic t_wide();
    src("89ABcdefzzzzzzzz");
    run(ATHN_W32);
    rd(8'h40, 32'h0000_CDEF);
    rd(8'h44, 32'h0000_89AB);
    rd(8'h48, 32'h0000_0000);
    flags(3'b100);
    src("0123456789abcdef");
    run(ATHN_W64);
    rd(8'h40, 32'h0000_CDEF);
    rd(8'h44, 32'h0000_89AB);
    rd(8'h48, 32'h0000_4567);
    rd(8'h4C, 32'h0000_0123);
    flags(3'b000);
    src("f123456789abcdeG");
    run(ATHN_W64);
    rd(8'h4C, 32'h0000_0123);
    flags(3'b001);
    $display("test wide done");
  endtask
  task automatic t_irq();
    rd(8'h08, 32'h0000_0003);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h0C, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h08, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(8'h08, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0002);
    rd(8'h0C, 32'h0000_0002);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h08, 32'h0000_0002);
    rd(8'h08, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask
  task automatic t_modes();
    src("1111............");
    wr(8'h00, 32'h0000_0003);
    rd(8'h00, 32'h0000_0003);
    rd(8'h40, 32'h0000_1111);
    wr(8'h20, 32'h0000_3232);
    wr(8'h00, 32'h0000_0003);
    rd(8'h40, 32'h0000_1111);
    wr(8'h00, 32'h0000_0001);
    rd(8'h40, 32'h0000_2211);
    wr(8'h24, 32'h0000_3333);
    rd(8'h40, 32'h0000_2233);
    wr(8'h00, 32'h0000_0000);
    wr(8'h20, 32'h0000_3434);
    rd(8'h40, 32'h0000_2233);
    // reserved width in each-cycle mode: no conversion, no events
    wr(8'h08, 32'h0000_0003);
    wr(8'h00, 32'h0000_000D);
    rd(8'h00, 32'h0000_000D);
    rd(8'h08, 32'h0000_0000);
    rd(8'h40, 32'h0000_2233);
    wr(8'h00, 32'h0000_0000);
    $display("test modes done");
  endtask
  // request held while the clock enable is low must wait, then land
  task automatic t_ce();
    @(posedge i_clk);
    ce <= 1'b0;
    go <= 1'b1;
    we <= 1'b1;
    adr <= 8'h20;
    dat <= 32'h0000_3939;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk("stalled ack", {31'h0, ack}, 32'h0);
    @(posedge i_clk);
    ce <= 1'b1;
    while (done !== 1'b1) @(negedge i_clk);
    rd(8'h20, 32'h0000_3939);
    rd(8'h40, 32'h0000_2233);
    $display("test ce done");
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_w16();
    t_chars();
    t_wide();
    t_irq();
    t_modes();
    t_ce();
    summarize();
  end
endmodule
